//--- hdl/ubg_pkg.sv
// ubg_pkg: register map, field layout, reset values and prescale figures
// for the serial data buffer and baud generator block.
// assumes an 8-bit special-function register bus with 8-bit addresses.
package ubg_pkg;
   // register addresses on the sfr bus
   localparam logic [7:0] ADDR_DATA_BUFFER = 8'h99;
   localparam logic [7:0] ADDR_BAUD_CTRL   = 8'hAB;
   localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hAC;
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hAD;
   // control register fields
   localparam int         CTRL_RUN_BIT     = 6;
   localparam int         CTRL_PS_LSB      = 0;
   localparam logic [7:0] CTRL_WRITE_MASK  = 8'h43;
   // reset values
   localparam logic [7:0] RST_BYTE         = 8'h00;
   localparam logic [15:0] RST_COUNT       = 16'h0000;
   localparam logic [15:0] COUNT_ALL_ONES  = 16'hFFFF;
   // prescale select encodings
   typedef enum logic [1:0] {
      UBG_PS_DIV12 = 2'b00,
      UBG_PS_DIV4  = 2'b01,
      UBG_PS_DIV48 = 2'b10,
      UBG_PS_DIV1  = 2'b11
   } ubg_ps_t;
   // prescale terminal counts (divide ratio minus one)
   localparam logic [5:0] PS_LAST_DIV12    = 6'd11;
   localparam logic [5:0] PS_LAST_DIV4     = 6'd3;
   localparam logic [5:0] PS_LAST_DIV48    = 6'd47;
   localparam logic [5:0] PS_LAST_DIV1     = 6'd0;
   // transmit shifter: bits per frame (start, 8 data, stop)
   localparam logic [3:0] TX_FRAME_BITS    = 4'd10;
endpackage : ubg_pkg

//--- hdl/ubg_skid_buf.sv
// ubg_skid_buf: two-entry buffer with valid/ready on both sides.
// assumes one clock, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ubg_skid_buf #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   // elaboration check: a zero-width word cannot be stored
   if (WIDTH < 1) begin : g_width_chk
      $error("ubg_skid_buf: WIDTH must be at least 1");
   end

   logic [WIDTH-1:0] mem_q [2];
   logic [WIDTH-1:0] mem_d [2];
   logic             rd_q, rd_d, wr_q, wr_d;
   logic [1:0]       cnt_q, cnt_d;
   logic             push, pop;

   assign in_ready  = (cnt_q != 2'd2);
   assign out_valid = (cnt_q != 2'd0);
   assign out_data  = mem_q[rd_q]; // storage is flops
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // next pointers, count and storage
   always_comb begin
      mem_d = mem_q;
      rd_d  = rd_q;
      wr_d  = wr_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data;
         wr_d        = ~wr_q;
      end
      if (pop) rd_d = ~rd_q;
      if (push && !pop) cnt_d = cnt_q + 2'd1;
      else if (pop && !push) cnt_d = cnt_q - 2'd1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mem_q[0] <= '0;
         mem_q[1] <= '0;
         rd_q     <= 1'b0;
         wr_q     <= 1'b0;
         cnt_q    <= 2'd0;
      end else begin
         mem_q <= mem_d;
         rd_q  <= rd_d;
         wr_q  <= wr_d;
         cnt_q <= cnt_d;
      end
   end

   buf_no_overfill_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cnt_q != 2'd3)
      else $error("buffer count beyond two entries");
endmodule : ubg_skid_buf
`default_nettype wire

//--- hdl/ubg_baud_buffer.sv
// ubg_baud_buffer: serial data buffer and baud rate generator of a serial port.
// assumes a synchronous 8-bit sfr bus (addr, wr strobe, rd strobe) and a
// receive path elsewhere that delivers bytes with a valid strobe.
//
// What this block does
// - writing the data buffer address loads the transmit shifter byte.
// - every byte written while sfr_wr_ready is high starts its own serial transmission.
// - reading the data buffer returns the receive latch, reset zero.
// - run bit 6 clear stops generator and serial port; set runs it.
// - prescale field 1:0 divides by 12, 4, 48 or 1.
// - on counter rollover upper byte loads from reload high register.
// - on same rollover lower byte loads from reload low register.
// - control bits 5:2 read zero; software writes zero.
// - control bit 7 reads zero; software writes zero.
`timescale 1ns/1ps
`default_nettype none
module ubg_baud_buffer #(
   parameter int PS_WIDTH = 6
) (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_rd,
   output logic      [7:0] sfr_rdata,
   output logic            sfr_wr_ready,
   input  wire logic       rx_byte_valid,
   input  wire logic [7:0] rx_byte,
   output logic            baud_tick,
   output logic            tx_pin,
   output logic            tx_busy
);
   // elaboration check: the divide-by-48 terminal count must fit
   if (PS_WIDTH < 6) begin : g_ps_width_chk
      $error("ubg_baud_buffer: PS_WIDTH must hold 47");
   end

   // register state
   logic [7:0]          ctrl_q, ctrl_d;
   logic [7:0]          rl_low_q, rl_low_d;
   logic [7:0]          rl_high_q, rl_high_d;
   logic [7:0]          rx_latch_q, rx_latch_d;
   // generator state
   logic [PS_WIDTH-1:0] ps_cnt_q, ps_cnt_d;
   logic [15:0]         baud_cnt_q, baud_cnt_d;
   logic                tick_q, tick_d;
   // transmit shifter state
   logic [9:0]          shift_q, shift_d;
   logic [3:0]          bits_q, bits_d;
   logic                busy_q, busy_d;
   logic                line_q, line_d;

   logic                run;
   logic [PS_WIDTH-1:0] ps_last;
   logic                ps_tick;
   logic                wr_data;
   logic                buf_in_ready;
   logic                buf_out_valid;
   logic [7:0]          buf_out_data;
   logic                take_byte;

   assign run = ctrl_q[ubg_pkg::CTRL_RUN_BIT];

   // reads: data address gives the receive latch only, reserved bits are zero
   // reads have no side effect, so the mux follows the address alone
   always_comb begin
      unique case (sfr_addr)
         ubg_pkg::ADDR_DATA_BUFFER: sfr_rdata = rx_latch_q;
         ubg_pkg::ADDR_BAUD_CTRL:   sfr_rdata = ctrl_q & ubg_pkg::CTRL_WRITE_MASK;
         ubg_pkg::ADDR_RELOAD_LOW:  sfr_rdata = rl_low_q;
         ubg_pkg::ADDR_RELOAD_HIGH: sfr_rdata = rl_high_q;
         default:                   sfr_rdata = ubg_pkg::RST_BYTE;
      endcase
   end

   // register writes and receive latch capture
   always_comb begin
      ctrl_d     = ctrl_q;
      rl_low_d   = rl_low_q;
      rl_high_d  = rl_high_q;
      rx_latch_d = rx_latch_q;
      if (sfr_wr && sfr_addr == ubg_pkg::ADDR_BAUD_CTRL) begin
         ctrl_d = sfr_wdata & ubg_pkg::CTRL_WRITE_MASK; // reserved bits never stored
      end
      if (sfr_wr && sfr_addr == ubg_pkg::ADDR_RELOAD_LOW) rl_low_d = sfr_wdata;
      if (sfr_wr && sfr_addr == ubg_pkg::ADDR_RELOAD_HIGH) rl_high_d = sfr_wdata;
      if (rx_byte_valid) rx_latch_d = rx_byte;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_q     <= ubg_pkg::RST_BYTE;
         rl_low_q   <= ubg_pkg::RST_BYTE;
         rl_high_q  <= ubg_pkg::RST_BYTE;
         rx_latch_q <= ubg_pkg::RST_BYTE;
      end else begin
         ctrl_q     <= ctrl_d;
         rl_low_q   <= rl_low_d;
         rl_high_q  <= rl_high_d;
         rx_latch_q <= rx_latch_d;
      end
   end

   // prescale terminal count from the select field
   always_comb begin
      unique case (ubg_pkg::ubg_ps_t'(ctrl_q[ubg_pkg::CTRL_PS_LSB +: 2]))
         ubg_pkg::UBG_PS_DIV12: ps_last = PS_WIDTH'(ubg_pkg::PS_LAST_DIV12);
         ubg_pkg::UBG_PS_DIV4:  ps_last = PS_WIDTH'(ubg_pkg::PS_LAST_DIV4);
         ubg_pkg::UBG_PS_DIV48: ps_last = PS_WIDTH'(ubg_pkg::PS_LAST_DIV48);
         ubg_pkg::UBG_PS_DIV1:  ps_last = PS_WIDTH'(ubg_pkg::PS_LAST_DIV1);
      endcase
   end

   // a select change mid-count could overshoot ps_last, so compare with >=
   assign ps_tick = run && (ps_cnt_q >= ps_last);

   // prescaler and 16-bit baud counter with reload on rollover
   // the prescaler restarts from zero on stop, so a restart gives a full
   // first prescale period; the counter keeps its value across a stop
   always_comb begin
      ps_cnt_d   = ps_cnt_q;
      baud_cnt_d = baud_cnt_q;
      tick_d     = 1'b0;
      if (!run) begin
         ps_cnt_d = '0;
      end else if (ps_tick) begin
         ps_cnt_d = '0;
         if (baud_cnt_q == ubg_pkg::COUNT_ALL_ONES) begin
            baud_cnt_d = {rl_high_q, rl_low_q};
            tick_d     = 1'b1;
         end else begin
            baud_cnt_d = baud_cnt_q + 16'h0001;
         end
      end else begin
         ps_cnt_d = ps_cnt_q + PS_WIDTH'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ps_cnt_q   <= '0;
         baud_cnt_q <= ubg_pkg::RST_COUNT;
         tick_q     <= 1'b0;
      end else begin
         ps_cnt_q   <= ps_cnt_d;
         baud_cnt_q <= baud_cnt_d;
         tick_q     <= tick_d;
      end
   end

   assign baud_tick = tick_q;

   // written bytes queue here so a write during a frame is not lost
   assign wr_data      = sfr_wr && (sfr_addr == ubg_pkg::ADDR_DATA_BUFFER);
   assign sfr_wr_ready = buf_in_ready;

   ubg_skid_buf #(
      .WIDTH (8)
   ) u_tx_buf (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (wr_data),
      .in_ready  (buf_in_ready),
      .in_data   (sfr_wdata),
      .out_valid (buf_out_valid),
      .out_ready (take_byte),
      .out_data  (buf_out_data)
   );

   // shifter takes a byte only when idle and the generator runs
   assign take_byte = buf_out_valid && !busy_q && run;

   // transmit shifter: start bit, 8 data bits lsb first, stop bit
   // the start bit begins on a baud event, so it is a full bit long; one
   // extra event after the stop bit returns to idle, which costs up to one
   // bit time of idle line between back-to-back frames
   always_comb begin
      shift_d = shift_q;
      bits_d  = bits_q;
      busy_d  = busy_q;
      line_d  = line_q;
      if (take_byte) begin
         shift_d = {1'b1, buf_out_data, 1'b0};
         bits_d  = ubg_pkg::TX_FRAME_BITS;
         busy_d  = 1'b1;
      end else if (busy_q && tick_q && run) begin // halted when run clear
         line_d  = shift_q[0];
         shift_d = {1'b1, shift_q[9:1]};
         bits_d  = bits_q - 4'd1;
         if (bits_q == 4'd0) begin
            busy_d = 1'b0;
            line_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         shift_q <= '1;
         bits_q  <= 4'd0;
         busy_q  <= 1'b0;
         line_q  <= 1'b1;
      end else begin
         shift_q <= shift_d;
         bits_q  <= bits_d;
         busy_q  <= busy_d;
         line_q  <= line_d;
      end
   end

   assign tx_pin  = line_q;
   assign tx_busy = busy_q;

   // checks: register reads, stores and the receive latch
   rd_is_latch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sfr_addr == ubg_pkg::ADDR_DATA_BUFFER |-> sfr_rdata == rx_latch_q)
      else $error("data read not from receive latch");
   rx_capture_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_byte_valid |=> rx_latch_q == $past(rx_byte))
      else $error("receive latch missed byte");
   rx_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !rx_byte_valid |=> $stable(rx_latch_q))
      else $error("receive latch changed without a byte");
   ctrl_store_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sfr_wr && sfr_addr == ubg_pkg::ADDR_BAUD_CTRL |=> ctrl_q == ($past(sfr_wdata) & ubg_pkg::CTRL_WRITE_MASK))
      else $error("control write not stored");
   rl_high_wr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sfr_wr && sfr_addr == ubg_pkg::ADDR_RELOAD_HIGH |=> rl_high_q == $past(sfr_wdata))
      else $error("reload high write not stored");
   rl_low_wr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sfr_wr && sfr_addr == ubg_pkg::ADDR_RELOAD_LOW |=> rl_low_q == $past(sfr_wdata))
      else $error("reload low write not stored");
   ctrl_resv_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sfr_addr == ubg_pkg::ADDR_BAUD_CTRL |-> sfr_rdata[5:2] == 4'h0)
      else $error("reserved bits 5:2 not zero");
   ctrl_bit7_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sfr_addr == ubg_pkg::ADDR_BAUD_CTRL |-> !sfr_rdata[7])
      else $error("reserved bit 7 not zero");
   // checks: generator stop, prescale and counter stepping
   stop_no_tick_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !run |-> !tick_d ##1 baud_cnt_q == $past(baud_cnt_q))
      else $error("counter moved while stopped");
   stop_no_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !run && !busy_q |=> !busy_q)
      else $error("transmission started while stopped");
   div1_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      run && ctrl_q[1:0] == 2'b11 && $stable(ctrl_q) && baud_cnt_q != 16'hFFFF
      |=> baud_cnt_q == $past(baud_cnt_q) + 16'h0001)
      else $error("divide by one not counting each cycle");
   div4_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      run && ctrl_q[1:0] == 2'b01 && ps_cnt_q == '0 ##1 run && ctrl_q[1:0] == 2'b01
      |-> $stable(baud_cnt_q))
      else $error("divide by four stepped early");
   ps_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      run && !ps_tick |=> ps_cnt_q == $past(ps_cnt_q) + PS_WIDTH'(1))
      else $error("prescaler did not advance");
   ps_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ps_tick |=> ps_cnt_q == '0)
      else $error("prescaler did not restart");
   cnt_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ps_tick && baud_cnt_q != 16'hFFFF |=> baud_cnt_q == $past(baud_cnt_q) + 16'h0001)
      else $error("counter missed a prescaled tick");
   tick_only_roll_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !(ps_tick && baud_cnt_q == 16'hFFFF) |=> !baud_tick)
      else $error("baud event without rollover");
   reload_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ps_tick && baud_cnt_q == 16'hFFFF |=> baud_cnt_q[15:8] == $past(rl_high_q))
      else $error("high byte not reloaded");
   reload_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ps_tick && baud_cnt_q == 16'hFFFF |=> baud_cnt_q[7:0] == $past(rl_low_q) && baud_tick)
      else $error("low byte not reloaded");
   tick_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      baud_tick |=> !baud_tick || $past(ctrl_q[1:0]) == 2'b11)
      else $error("baud event longer than one cycle");
   // checks: transmit frame shape
   tx_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      take_byte |=> busy_q && shift_q == {1'b1, $past(buf_out_data), 1'b0})
      else $error("written byte not loaded into shifter");
   tx_launch_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wr_data && buf_in_ready && run && !busy_q && !buf_out_valid |=> ##1 busy_q)
      else $error("write did not start a transmission");
   tx_idle_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !busy_q |-> tx_pin)
      else $error("line not idle high");
   tx_start_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      busy_q && tick_q && run && bits_q == ubg_pkg::TX_FRAME_BITS |=> !tx_pin)
      else $error("frame did not open with a start bit");
   tx_bit_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      busy_q && !(tick_q && run) |=> $stable(tx_pin))
      else $error("line changed between baud events");
   tx_frame_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      busy_q && tick_q && run && bits_q == 4'd0 |=> !busy_q && tx_pin)
      else $error("frame did not end idle");

   // covers for the main scenarios
   tx_frame_c:  cover property (@(posedge clk_sys) disable iff (!rst_n) busy_q ##1 !busy_q);
   rollover_c:  cover property (@(posedge clk_sys) disable iff (!rst_n) baud_tick);
   buf_full_c:  cover property (@(posedge clk_sys) disable iff (!rst_n) !buf_in_ready);
   rx_read_c:   cover property (@(posedge clk_sys) disable iff (!rst_n)
      sfr_rd && sfr_addr == ubg_pkg::ADDR_DATA_BUFFER && sfr_rdata != 8'h00);
   stall_c:     cover property (@(posedge clk_sys) disable iff (!rst_n) !run && !buf_in_ready);
endmodule : ubg_baud_buffer
`default_nettype wire

//--- sim/ubg_serial_peer.sv
// ubg_serial_peer: remote serial peer; decodes frames on tx_pin, delivers
// received bytes as the receive logic would. assumes a fixed bit period.
`timescale 1ns/1ps
`default_nettype none
module ubg_serial_peer #(
   parameter int BIT_CYCLES = 16
) (
   input  wire logic       clk_sys,
   input  wire logic       tx_pin,
   output logic            rx_byte_valid,
   output logic      [7:0] rx_byte
);
   logic [7:0] got[$];
   logic [7:0] shift;
   logic       start_ok;
   int         frame_errs = 0;

   initial begin
      rx_byte_valid = 1'b0;
      rx_byte       = 8'h00;
   end

   // one received byte; data line shows the inverse afterwards, never stale
   task automatic send_byte(input logic [7:0] b);
      @(posedge clk_sys) #1;
      rx_byte       = b;
      rx_byte_valid = 1'b1;
      @(posedge clk_sys) #1;
      rx_byte_valid = 1'b0;
      rx_byte       = ~b;
   endtask : send_byte

   // mid-bit sampling on the falling clock, so no race with the tx register
   initial forever begin
      @(negedge tx_pin);
      repeat (BIT_CYCLES / 2) @(negedge clk_sys);
      start_ok = (tx_pin === 1'b0);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYCLES) @(negedge clk_sys);
         shift[i] = tx_pin; // lsb first
      end
      repeat (BIT_CYCLES) @(negedge clk_sys);
      if (start_ok && tx_pin === 1'b1) got.push_back(shift);
      else frame_errs++;
   end
endmodule : ubg_serial_peer
`default_nettype wire

//--- sim/tb.sv
// tb: register-level tests of the data buffer and baud generator.
// assumes the design's sfr bus contract and the serial peer model.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic       clk_sys   = 1'b0;
   logic       rst_n     = 1'b0;
   logic [7:0] sfr_addr  = 8'h00;
   logic [7:0] sfr_wdata = 8'h00;
   logic       sfr_wr    = 1'b0;
   logic       sfr_rd    = 1'b0;
   logic [7:0] sfr_rdata, rx_byte, v;
   logic       sfr_wr_ready, rx_byte_valid, baud_tick, tx_pin, tx_busy;
   int         bad_count = 0;
   int         n_checks  = 0;
   int         n;
   int         div[4] = '{12, 4, 48, 1};

   always #25 clk_sys = ~clk_sys;

   ubg_baud_buffer dut (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_wr_ready(sfr_wr_ready),
      .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .baud_tick(baud_tick), .tx_pin(tx_pin),
      .tx_busy(tx_busy));
   ubg_serial_peer #(.BIT_CYCLES(16)) peer (.clk_sys(clk_sys), .tx_pin(tx_pin),
      .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys) #1;
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      @(posedge clk_sys) #1;
      sfr_wr    = 1'b0;
   endtask : wr

   // rdata is combinational, so it is taken mid-cycle
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys) #1;
      sfr_addr = a;
      sfr_rd   = 1'b1;
      #20 v    = sfr_rdata;
      @(posedge clk_sys) #1;
      sfr_rd   = 1'b0;
      check(v, e);
   endtask : rd

   // cycles until the next tick; bounded so a dead generator cannot hang
   task automatic wait_tick(output int c);
      c = 0;
      do begin
         @(negedge clk_sys);
         c++;
      end while (baud_tick !== 1'b1 && c < 70000);
   endtask : wait_tick

   task automatic wait_got(input int k);
      n = 0;
      while (peer.got.size() < k && n < 5000) begin
         @(negedge clk_sys);
         n++;
      end
   endtask : wait_got

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : final_report

   // first rollover counts up from reset zero, 65536 cycles; the rest about 3000
   initial begin
      #(90000 * 50);
      bad_count++;
      final_report();
   end

   initial begin
      repeat (2) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      // reset values, unmapped place, reserved control bits
      foreach (div[i]) rd(8'hAB + 8'(i), 8'h00);
      rd(8'h99, 8'h00);
      check(tx_pin, 1'b1);
      wr(8'hAA, 8'h5A);
      rd(8'hAA, 8'h00);
      wr(8'hAB, 8'h03); // reserved bits written zero
      rd(8'hAB, 8'h03);
      wr(8'hAB, 8'h43); // run at divide by one from the counter reset value
      rd(8'hAB, 8'h43);
      $display("test registers done");
      // 3 counts per rollover through every prescale code
      wr(8'hAD, 8'hFF);
      wr(8'hAC, 8'hFD);
      wait_tick(n); // first rollover, counting up from zero
      check(16'(n < 70000), 16'd1);
      foreach (div[i]) begin
         wr(8'hAB, 8'h40 | 8'(i));
         repeat (3) wait_tick(n);
         check(16'(n), 16'(3 * div[i]));
      end
      // both reload bytes: 0xfefe..0xffff is 258 counts
      wr(8'hAD, 8'hFE);
      wr(8'hAC, 8'hFE);
      wr(8'hAB, 8'h43);
      repeat (3) wait_tick(n);
      check(16'(n), 16'd258);
      wr(8'hAC, 8'hFC);
      wr(8'hAD, 8'hFF);
      repeat (3) wait_tick(n);
      check(16'(n), 16'd4);
      $display("test generator done");
      // stopped: no ticks, shifter stalls, buffer fills and refuses
      wr(8'hAB, 8'h01);
      wr(8'h99, 8'h11);
      wr(8'h99, 8'h22);
      n = 0;
      repeat (300) begin
         @(negedge clk_sys);
         if (baud_tick === 1'b1 || tx_pin !== 1'b1) n++;
      end
      check(16'(n), 16'd0);
      check(sfr_wr_ready, 1'b0);
      wr(8'h99, 8'h33);
      wr(8'hAB, 8'h41);
      wait_got(2);
      repeat (400) @(negedge clk_sys);
      check(16'(peer.got.size()), 16'd2);
      check(peer.got[0], 8'h11);
      check(peer.got[1], 8'h22);
      $display("test stall and buffer done");
      // back to back writes while running, receive during transmit
      wr(8'h99, 8'hA5);
      wr(8'h99, 8'h80);
      wr(8'h99, 8'h01);
      check(tx_busy, 1'b1);
      peer.send_byte(8'h5A);
      rd(8'h99, 8'h5A);
      wait_got(5);
      check(peer.got[2], 8'hA5);
      check(peer.got[3], 8'h80);
      check(peer.got[4], 8'h01);
      check(16'(peer.frame_errs), 16'd0);
      $display("test transmit receive done");
      final_report();
   end
endmodule : tb
`default_nettype wire
